/* File: verilog/srbc_pkg.sv */
//Function
// RQ1: read command loads selected value into result words
// RQ2: host waits 125 ns before reading results
// RQ3: host selects exactly one axis per command
// RQ4: results are binary, negatives two's complement
// RQ5: code 3eh returns mode register two, high zero
// RQ6: mode registers two, three only readable by command
// RQ7: code 3fh returns mode register three, high zero
// RQ8: code 40h returns multi-purpose mode, high zero
// RQ9: code 41h returns pin config one, high zero
// RQ10: code 42h returns pin config two, high zero
// RQ11: code 43h returns 32-bit ramp rate setting
// RQ12: code 44h returns 32-bit start rate setting
// RQ13: code 45h returns 32-bit target rate setting
// RQ14: code 46h returns signed pulse count goal
// RQ15: code 47h returns split length low, width high
// RQ16: code 48h captures data pins in serial mode
// RQ17: pin config three read, code unresolved, high zero
// RQ18: four-byte results split low and high halves
package srbc_pkg;

   // ****************************************************
   // command codes
   // ****************************************************
   localparam logic [7:0] CMD_MODE_TWO = 8'h3e;
   localparam logic [7:0] CMD_MODE_THREE = 8'h3f;
   localparam logic [7:0] CMD_MP_MODE = 8'h40;
   localparam logic [7:0] CMD_PIN_ONE = 8'h41;
   localparam logic [7:0] CMD_PIN_TWO = 8'h42;
   localparam logic [7:0] CMD_RAMP = 8'h43;
   localparam logic [7:0] CMD_START = 8'h44;
   localparam logic [7:0] CMD_TARGET = 8'h45;
   localparam logic [7:0] CMD_GOAL = 8'h46;
   localparam logic [7:0] CMD_SPLIT = 8'h47;
   localparam logic [7:0] CMD_INPUTS = 8'h48;
   // printed code clashes with 42h; default is a free code
   localparam logic [7:0] CMD_PIN_THREE_DEFAULT = 8'h4f;

   // ****************************************************
   // widths, reset values and timing
   // ****************************************************
   localparam int WORD_W = 16;
   localparam int AXES = 2;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam int CLK_MHZ = 40;
   localparam int READ_WAIT_NS = 125;
   localparam int READ_WAIT_CYC_RAW = (READ_WAIT_NS * CLK_MHZ) / 1000;
   localparam int READ_WAIT_CYC = (READ_WAIT_CYC_RAW < 1) ? 1 : READ_WAIT_CYC_RAW;
   localparam int RESULT_LAT_CYC = 1;

   // ****************************************************
   // decoded command kinds
   // ****************************************************
   typedef enum logic [3:0]
   {
      SRBC_K_NONE = 4'b0000,
      SRBC_K_MODE_TWO = 4'b0001,
      SRBC_K_MODE_THREE = 4'b0010,
      SRBC_K_MP_MODE = 4'b0011,
      SRBC_K_PIN_ONE = 4'b0100,
      SRBC_K_PIN_TWO = 4'b0101,
      SRBC_K_PIN_THREE = 4'b0110,
      SRBC_K_RAMP = 4'b0111,
      SRBC_K_START = 4'b1000,
      SRBC_K_TARGET = 4'b1001,
      SRBC_K_GOAL = 4'b1010,
      SRBC_K_SPLIT = 4'b1011,
      SRBC_K_INPUTS = 4'b1100
   } srbc_kind_t;

endpackage : srbc_pkg

/* File: verilog/srbc_pin_sync.sv */
`timescale 1ns/1ps
module srbc_pin_sync
#(
   parameter int W = 16
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   import srbc_pkg::*;

   // ****************************************************
   // two-stage synchroniser per pin
   // ****************************************************
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic meta;
         logic stable;
         always_ff @(posedge i_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               meta <= 1'b0;
               stable <= 1'b0;
            end
            else
            begin
               meta <= i_async[g];
               stable <= meta;
            end
         end
         assign o_sync[g] = stable;
      end
   endgenerate

endmodule : srbc_pin_sync

/* File: verilog/srbc_code_decode.sv */
`timescale 1ns/1ps
module srbc_code_decode
#(
   parameter logic [7:0] PIN_THREE_CODE = srbc_pkg::CMD_PIN_THREE_DEFAULT
)
(
   input wire logic [7:0] i_code,
   output srbc_pkg::srbc_kind_t o_kind,
   output logic o_known
);
   import srbc_pkg::*;

   // ****************************************************
   // code to kind
   // ****************************************************
   // pin config three is compared first so a clash with another code still decodes it
   assign o_kind = (i_code == PIN_THREE_CODE) ? SRBC_K_PIN_THREE : // RQ17
                   (i_code == CMD_MODE_TWO) ? SRBC_K_MODE_TWO :
                   (i_code == CMD_MODE_THREE) ? SRBC_K_MODE_THREE :
                   (i_code == CMD_MP_MODE) ? SRBC_K_MP_MODE :
                   (i_code == CMD_PIN_ONE) ? SRBC_K_PIN_ONE :
                   (i_code == CMD_PIN_TWO) ? SRBC_K_PIN_TWO :
                   (i_code == CMD_RAMP) ? SRBC_K_RAMP :
                   (i_code == CMD_START) ? SRBC_K_START :
                   (i_code == CMD_TARGET) ? SRBC_K_TARGET :
                   (i_code == CMD_GOAL) ? SRBC_K_GOAL :
                   (i_code == CMD_SPLIT) ? SRBC_K_SPLIT :
                   (i_code == CMD_INPUTS) ? SRBC_K_INPUTS :
                   SRBC_K_NONE;
   assign o_known = (o_kind != SRBC_K_NONE);

endmodule : srbc_code_decode

/* File: verilog/srbc_readback.sv */
`timescale 1ns/1ps
module srbc_readback
#(
   parameter logic [7:0] PIN_THREE_CODE = srbc_pkg::CMD_PIN_THREE_DEFAULT
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_wr,
   input wire logic [7:0] i_cmd_code,
   input wire logic [1:0] i_axis_sel,
   input wire logic i_serial_mode,
   input wire logic [1:0][15:0] i_mode_write_reg_two,
   input wire logic [1:0][15:0] i_mode_write_reg_three,
   input wire logic [1:0][15:0] i_multi_purpose_mode,
   input wire logic [1:0][15:0] i_pin_cfg_one,
   input wire logic [1:0][15:0] i_pin_cfg_two,
   input wire logic [1:0][15:0] i_pin_cfg_three,
   input wire logic [1:0][31:0] i_ramp_rate_setting,
   input wire logic [1:0][31:0] i_start_rate_setting,
   input wire logic [1:0][31:0] i_target_rate_setting,
   input wire logic [1:0][31:0] i_pulse_count_goal,
   input wire logic [1:0][15:0] i_split_length,
   input wire logic [1:0][15:0] i_split_width,
   input wire logic [15:0] i_data_pins,
   output logic [15:0] o_result_low_word,
   output logic [15:0] o_result_high_word,
   output logic o_result_ready,
   output logic o_cmd_unknown
);
   import srbc_pkg::*;

   // ****************************************************
   // axis selection helpers
   // ****************************************************
   // a bad axis field picks axis x rather than blending both axes
   function automatic logic pick_axis(input logic [1:0] sel);
      pick_axis = (sel == 2'b10);
   endfunction : pick_axis

   function automatic logic [15:0] pick16(input logic [1:0] sel, input logic [1:0][15:0] v);
      pick16 = pick_axis(sel) ? v[1] : v[0];
   endfunction : pick16

   function automatic logic [31:0] pick32(input logic [1:0] sel, input logic [1:0][31:0] v);
      pick32 = pick_axis(sel) ? v[1] : v[0];
   endfunction : pick32

   // ****************************************************
   // decode and input capture
   // ****************************************************
   srbc_kind_t kind;
   logic known;
   logic [15:0] pins_sync;

   srbc_code_decode #(.PIN_THREE_CODE(PIN_THREE_CODE)) u_decode
   (
      .i_code(i_cmd_code),
      .o_kind(kind),
      .o_known(known)
   );

   srbc_pin_sync #(.W(WORD_W)) u_pins
   (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_async(i_data_pins),
      .o_sync(pins_sync)
   );

   // ****************************************************
   // selected per-axis values
   // ****************************************************
   // mode registers two and three leave the block only through these read paths
   logic [15:0] sel_mode_two;
   logic [15:0] sel_mode_three;
   logic [15:0] sel_mp_mode;
   logic [15:0] sel_pin_one;
   logic [15:0] sel_pin_two;
   logic [15:0] sel_pin_three;
   logic [31:0] sel_ramp;
   logic [31:0] sel_start;
   logic [31:0] sel_target;
   logic [31:0] sel_goal;
   logic [15:0] sel_split_len;
   logic [15:0] sel_split_wid;
   logic [15:0] inputs_word;

   assign sel_mode_two = pick16(i_axis_sel, i_mode_write_reg_two); // RQ6
   assign sel_mode_three = pick16(i_axis_sel, i_mode_write_reg_three); // RQ6
   assign sel_mp_mode = pick16(i_axis_sel, i_multi_purpose_mode);
   assign sel_pin_one = pick16(i_axis_sel, i_pin_cfg_one);
   assign sel_pin_two = pick16(i_axis_sel, i_pin_cfg_two);
   assign sel_pin_three = pick16(i_axis_sel, i_pin_cfg_three);
   // settings are read live, so values loaded by a synchronous action show up
   assign sel_ramp = pick32(i_axis_sel, i_ramp_rate_setting); // RQ11
   assign sel_start = pick32(i_axis_sel, i_start_rate_setting); // RQ12
   assign sel_target = pick32(i_axis_sel, i_target_rate_setting); // RQ13
   assign sel_goal = pick32(i_axis_sel, i_pulse_count_goal); // RQ14
   assign sel_split_len = pick16(i_axis_sel, i_split_length);
   assign sel_split_wid = pick16(i_axis_sel, i_split_width);
   // in parallel bus mode the data pins carry the bus itself, so zero is returned
   assign inputs_word = i_serial_mode ? pins_sync : RESULT_RESET; // RQ16

   // ****************************************************
   // result selection
   // ****************************************************
   logic [15:0] next_low;
   logic [15:0] next_high;
   logic load;

   always_comb
   begin
      next_low = RESULT_RESET;
      next_high = RESULT_RESET;
      unique case (kind)
         SRBC_K_NONE:
         begin
            next_low = o_result_low_word;
            next_high = o_result_high_word;
         end
         SRBC_K_MODE_TWO: next_low = sel_mode_two; // RQ5
         SRBC_K_MODE_THREE: next_low = sel_mode_three; // RQ7
         SRBC_K_MP_MODE: next_low = sel_mp_mode; // RQ8
         SRBC_K_PIN_ONE: next_low = sel_pin_one; // RQ9
         SRBC_K_PIN_TWO: next_low = sel_pin_two; // RQ10
         SRBC_K_PIN_THREE: next_low = sel_pin_three; // RQ17
         SRBC_K_RAMP: {next_high, next_low} = sel_ramp; // RQ18
         SRBC_K_START: {next_high, next_low} = sel_start; // RQ18
         SRBC_K_TARGET: {next_high, next_low} = sel_target; // RQ18
         SRBC_K_GOAL: {next_high, next_low} = sel_goal; // RQ4
         SRBC_K_SPLIT:
         begin
            next_low = sel_split_len; // RQ15
            next_high = sel_split_wid; // RQ15
         end
         SRBC_K_INPUTS: next_low = inputs_word; // RQ16
         default:
         begin
            next_low = o_result_low_word;
            next_high = o_result_high_word;
         end
      endcase
   end

   assign load = i_cmd_wr && known; // RQ1

   // ****************************************************
   // result registers
   // ****************************************************
   // one cycle from the command write, well inside the host's wait
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_result_low_word <= RESULT_RESET;
         o_result_high_word <= RESULT_RESET;
      end
      else if (load)
      begin
         o_result_low_word <= next_low; // RQ1
         o_result_high_word <= next_high; // RQ1
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_result_ready <= 1'b0;
         o_cmd_unknown <= 1'b0;
      end
      else
      begin
         o_result_ready <= load;
         o_cmd_unknown <= i_cmd_wr && !known;
      end
   end

   // ****************************************************
   // assertions
   // ****************************************************
   localparam int WAIT_MAX = READ_WAIT_CYC;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_cmd(logic [7:0] code, logic guard);
      i_cmd_wr && (i_cmd_code == code) && guard;
   endsequence

   sequence s_high_zero;
      o_result_high_word == 16'h0000;
   endsequence

   property p_ready_in_time;
      i_cmd_wr && known |-> ##[1:WAIT_MAX] o_result_ready;
   endproperty
   a_ready_in_time: assert property (p_ready_in_time) else $error("result not ready in time"); // RQ1

   property p_hold_when_idle;
      !i_cmd_wr |=> $stable(o_result_low_word) && $stable(o_result_high_word);
   endproperty
   a_hold_when_idle: assert property (p_hold_when_idle) else $error("result changed without command"); // RQ1

   property p_mode_two;
      s_cmd(CMD_MODE_TWO, PIN_THREE_CODE != CMD_MODE_TWO)
         |=> (o_result_low_word == $past(sel_mode_two)) and s_high_zero;
   endproperty
   a_mode_two: assert property (p_mode_two) else $error("mode two readback wrong"); // RQ5

   property p_mode_three;
      s_cmd(CMD_MODE_THREE, PIN_THREE_CODE != CMD_MODE_THREE)
         |=> (o_result_low_word == $past(sel_mode_three)) and s_high_zero;
   endproperty
   a_mode_three: assert property (p_mode_three) else $error("mode three readback wrong"); // RQ7

   property p_mode_axis;
      s_cmd(CMD_MODE_TWO, (i_axis_sel == 2'b10) && (PIN_THREE_CODE != CMD_MODE_TWO))
         |=> o_result_low_word == $past(i_mode_write_reg_two[1]);
   endproperty
   a_mode_axis: assert property (p_mode_axis) else $error("mode two read from wrong axis"); // RQ6

   property p_mp_mode;
      s_cmd(CMD_MP_MODE, PIN_THREE_CODE != CMD_MP_MODE)
         |=> (o_result_low_word == $past(sel_mp_mode)) and s_high_zero;
   endproperty
   a_mp_mode: assert property (p_mp_mode) else $error("multi-purpose mode readback wrong"); // RQ8

   property p_pin_one;
      s_cmd(CMD_PIN_ONE, PIN_THREE_CODE != CMD_PIN_ONE)
         |=> (o_result_low_word == $past(sel_pin_one)) and s_high_zero;
   endproperty
   a_pin_one: assert property (p_pin_one) else $error("pin config one readback wrong"); // RQ9

   property p_pin_two;
      s_cmd(CMD_PIN_TWO, PIN_THREE_CODE != CMD_PIN_TWO)
         |=> (o_result_low_word == $past(sel_pin_two)) and s_high_zero;
   endproperty
   a_pin_two: assert property (p_pin_two) else $error("pin config two readback wrong"); // RQ10

   property p_pin_three;
      s_cmd(PIN_THREE_CODE, 1'b1) |=> (o_result_low_word == $past(sel_pin_three)) and s_high_zero;
   endproperty
   a_pin_three: assert property (p_pin_three) else $error("pin config three readback wrong"); // RQ17

   property p_ramp;
      s_cmd(CMD_RAMP, PIN_THREE_CODE != CMD_RAMP)
         |=> {o_result_high_word, o_result_low_word} == $past(sel_ramp);
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp rate readback wrong"); // RQ11

   property p_start;
      s_cmd(CMD_START, PIN_THREE_CODE != CMD_START)
         |=> {o_result_high_word, o_result_low_word} == $past(sel_start);
   endproperty
   a_start: assert property (p_start) else $error("start rate readback wrong"); // RQ12

   property p_target;
      s_cmd(CMD_TARGET, PIN_THREE_CODE != CMD_TARGET)
         |=> {o_result_high_word, o_result_low_word} == $past(sel_target);
   endproperty
   a_target: assert property (p_target) else $error("target rate readback wrong"); // RQ13

   property p_goal;
      s_cmd(CMD_GOAL, PIN_THREE_CODE != CMD_GOAL)
         |=> {o_result_high_word, o_result_low_word} == $past(sel_goal);
   endproperty
   a_goal: assert property (p_goal) else $error("pulse count goal readback wrong"); // RQ14

   property p_goal_sign;
      s_cmd(CMD_GOAL, PIN_THREE_CODE != CMD_GOAL)
         |=> o_result_high_word[15] == $past(sel_goal[31]);
   endproperty
   a_goal_sign: assert property (p_goal_sign) else $error("pulse count goal sign lost"); // RQ4

   property p_halves;
      s_cmd(CMD_RAMP, PIN_THREE_CODE != CMD_RAMP)
         |=> (o_result_low_word == $past(sel_ramp[15:0])) && (o_result_high_word == $past(sel_ramp[31:16]));
   endproperty
   a_halves: assert property (p_halves) else $error("four-byte halves swapped"); // RQ18

   property p_split;
      s_cmd(CMD_SPLIT, PIN_THREE_CODE != CMD_SPLIT)
         |=> (o_result_low_word == $past(sel_split_len)) && (o_result_high_word == $past(sel_split_wid));
   endproperty
   a_split: assert property (p_split) else $error("split pulse readback wrong"); // RQ15

   property p_inputs;
      s_cmd(CMD_INPUTS, i_serial_mode && (PIN_THREE_CODE != CMD_INPUTS))
         |=> (o_result_low_word == $past(pins_sync)) and s_high_zero;
   endproperty
   a_inputs: assert property (p_inputs) else $error("input levels readback wrong"); // RQ16

   property p_inputs_parallel;
      s_cmd(CMD_INPUTS, !i_serial_mode && (PIN_THREE_CODE != CMD_INPUTS))
         |=> (o_result_low_word == 16'h0000) and s_high_zero;
   endproperty
   a_inputs_parallel: assert property (p_inputs_parallel) else $error("inputs read in parallel mode"); // RQ16

   property p_unknown;
      i_cmd_wr && !known |=> o_cmd_unknown && !o_result_ready && $stable(o_result_low_word);
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown code changed results"); // RQ1

endmodule : srbc_readback

/* File: tb/srbc_host_model.sv */
`timescale 1ns/1ps
module srbc_host_model
(
   input wire logic i_clk,
   output logic o_cmd_wr,
   output logic [7:0] o_cmd_code,
   output logic [1:0] o_axis_sel,
   input wire logic [15:0] i_result_low_word,
   input wire logic [15:0] i_result_high_word,
   input wire logic i_result_ready,
   input wire logic i_cmd_unknown
);
   import srbc_pkg::*;

   // ****************************************************
   // host side of the command register
   // ****************************************************
   initial
   begin
      o_cmd_wr = 1'b0;
      o_cmd_code = 8'h00;
      o_axis_sel = 2'b00;
   end

   // entered at a falling edge; strobe stays up so back to back calls never lower it
   task automatic issue(input logic [7:0] code, input logic [1:0] axis, output logic rdy, output logic unk);
      o_cmd_wr = 1'b1;
      o_cmd_code = code;
      o_axis_sel = axis;
      @(negedge i_clk);
      rdy = i_result_ready;
      unk = i_cmd_unknown;
   endtask : issue

   // idle bus shows inverted garbage so a stale code cannot pass for a fresh one
   task automatic release_bus;
      o_cmd_wr = 1'b0;
      o_cmd_code = ~o_cmd_code;
      o_axis_sel = ~o_axis_sel;
   endtask : release_bus

   task automatic fetch(output logic [15:0] lo, output logic [15:0] hi);
      repeat (READ_WAIT_CYC) @(negedge i_clk);
      lo = i_result_low_word;
      hi = i_result_high_word;
   endtask : fetch

endmodule : srbc_host_model

/* File: tb/tb_setting_readback_commands.sv */
`timescale 1ns/1ps
module tb_setting_readback_commands;
   import srbc_pkg::*;

   // ****************************************************
   // stimulus and observation
   // ****************************************************
   logic i_clk;
   logic i_nrst;
   logic cmd_wr;
   logic [7:0] cmd_code;
   logic [1:0] axis_sel;
   logic serial_mode;
   logic [1:0][15:0] m2, m3, mpm, p1, p2, p3, slen, swid;
   logic [1:0][31:0] ramp, start, targ, goal;
   logic [15:0] pins;
   logic [15:0] res_lo, res_hi;
   logic res_rdy, res_unk;
   logic rdy_s, unk_s, rdy_b;
   logic [15:0] lo_s, hi_s;
   int n_mismatch;
   int checks;
   logic [7:0] codes [12] = '{CMD_MODE_TWO, CMD_MODE_THREE, CMD_MP_MODE, CMD_PIN_ONE, CMD_PIN_TWO, CMD_RAMP,
      CMD_START, CMD_TARGET, CMD_GOAL, CMD_SPLIT, CMD_INPUTS, CMD_PIN_THREE_DEFAULT};

   srbc_readback srbc_readback_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_wr(cmd_wr), .i_cmd_code(cmd_code),
      .i_axis_sel(axis_sel), .i_serial_mode(serial_mode), .i_mode_write_reg_two(m2),
      .i_mode_write_reg_three(m3), .i_multi_purpose_mode(mpm), .i_pin_cfg_one(p1), .i_pin_cfg_two(p2),
      .i_pin_cfg_three(p3), .i_ramp_rate_setting(ramp), .i_start_rate_setting(start),
      .i_target_rate_setting(targ), .i_pulse_count_goal(goal), .i_split_length(slen), .i_split_width(swid),
      .i_data_pins(pins), .o_result_low_word(res_lo), .o_result_high_word(res_hi),
      .o_result_ready(res_rdy), .o_cmd_unknown(res_unk));

   srbc_host_model srbc_host_model_i (.i_clk(i_clk), .o_cmd_wr(cmd_wr), .o_cmd_code(cmd_code),
      .o_axis_sel(axis_sel), .i_result_low_word(res_lo), .i_result_high_word(res_hi),
      .i_result_ready(res_rdy), .i_cmd_unknown(res_unk));

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // ****************************************************
   // expected values and checks
   // ****************************************************
   function automatic logic [31:0] exp_of(input logic [7:0] c, input logic [1:0] a);
      int k;
      k = (a == 2'b10) ? 1 : 0;
      case (c)
         CMD_MODE_TWO: exp_of = {16'h0000, m2[k]};
         CMD_MODE_THREE: exp_of = {16'h0000, m3[k]};
         CMD_MP_MODE: exp_of = {16'h0000, mpm[k]};
         CMD_PIN_ONE: exp_of = {16'h0000, p1[k]};
         CMD_PIN_TWO: exp_of = {16'h0000, p2[k]};
         CMD_PIN_THREE_DEFAULT: exp_of = {16'h0000, p3[k]};
         CMD_RAMP: exp_of = ramp[k];
         CMD_START: exp_of = start[k];
         CMD_TARGET: exp_of = targ[k];
         CMD_GOAL: exp_of = goal[k];
         CMD_SPLIT: exp_of = {swid[k], slen[k]};
         CMD_INPUTS: exp_of = serial_mode ? {16'h0000, pins} : 32'h0000_0000;
         default: exp_of = 32'h0000_0000;
      endcase
   endfunction : exp_of

   task automatic check(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : check

   task automatic read_cmd(input logic [7:0] c, input logic [1:0] a);
      srbc_host_model_i.issue(c, a, rdy_s, unk_s);
      srbc_host_model_i.release_bus();
      check({30'h0, rdy_s, unk_s}, 32'h2);
      srbc_host_model_i.fetch(lo_s, hi_s);
      check({hi_s, lo_s}, exp_of(c, a));
   endtask : read_cmd

   // refused code: flag only, words keep the previous answer
   task automatic bad_cmd(input logic [7:0] c, input logic [31:0] prev);
      srbc_host_model_i.issue(c, 2'b01, rdy_s, unk_s);
      srbc_host_model_i.release_bus();
      check({30'h0, rdy_s, unk_s}, 32'h1);
      srbc_host_model_i.fetch(lo_s, hi_s);
      check({hi_s, lo_s}, prev);
   endtask : bad_cmd

   task automatic wrap_up;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // ****************************************************
   // tests
   // ****************************************************
   initial
   begin
      n_mismatch = 0;
      checks = 0;
      i_nrst = 1'b0;
      serial_mode = 1'b0;
      pins = 16'ha5c3;
      m2 = {16'h2b2e, 16'h1a1e};
      m3 = {16'h2c3f, 16'h1d3f};
      mpm = {16'h2440, 16'h1440};
      p1 = {16'h2541, 16'h1541};
      p2 = {16'h2642, 16'h1642};
      p3 = {16'h274f, 16'h174f};
      ramp = {32'h1fff_ffff, 32'h0001_2345};
      start = {32'h007a_1200, 32'h0000_0001};
      targ = {32'h0003_0d40, 32'h007a_1200};
      goal = {32'h8000_0002, 32'h7fff_fffe};
      slen = {16'hffff, 16'h0002};
      swid = {16'h0001, 16'hfffe};
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      check({res_hi, res_lo}, 32'h0);
      check({30'h0, res_rdy, res_unk}, 32'h0);
      i_nrst = 1'b1;
      // every code on both axes, 48h with parallel host reads zero
      for (int a = 1; a < 3; a++)
         for (int i = 0; i < 12; i++)
            read_cmd(codes[i], 2'(a));
      bad_cmd(8'h99, exp_of(CMD_PIN_THREE_DEFAULT, 2'b10));
      bad_cmd(8'h30, exp_of(CMD_PIN_THREE_DEFAULT, 2'b10));
      // back to back commands, second one wins
      srbc_host_model_i.issue(CMD_MODE_TWO, 2'b01, rdy_b, unk_s);
      srbc_host_model_i.issue(CMD_GOAL, 2'b10, rdy_s, unk_s);
      srbc_host_model_i.release_bus();
      check({30'h0, rdy_b, rdy_s}, 32'h3);
      srbc_host_model_i.fetch(lo_s, hi_s);
      check({hi_s, lo_s}, 32'h8000_0002);
      // serial host mode: pin levels captured through the synchroniser
      serial_mode = 1'b1;
      read_cmd(CMD_INPUTS, 2'b01);
      pins = 16'h5a3c;
      repeat (3) @(negedge i_clk);
      read_cmd(CMD_INPUTS, 2'b10);
      // reset in mid-run clears the result words
      i_nrst = 1'b0;
      @(negedge i_clk);
      check({res_hi, res_lo}, 32'h0);
      check({30'h0, res_rdy, res_unk}, 32'h0);
      @(negedge i_clk);
      i_nrst = 1'b1;
      read_cmd(CMD_SPLIT, 2'b10);
      wrap_up();
   end

   initial
   begin
      #(25 * 5000);
      n_mismatch++;
      wrap_up();
   end

endmodule : tb_setting_readback_commands
